// ===== rtl/ae_awb_pkg.sv
// constants for the exposure and colour balance controller
// assumes a 32-bit ahb-lite register bus, one word per register
package ae_awb_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_ALGO_SEL  = 8'h00;
   localparam logic [7:0] OFS_ROI_H     = 8'h04;
   localparam logic [7:0] OFS_MODES     = 8'h08;
   localparam logic [7:0] OFS_RATIO_LIM = 8'h0C;
   localparam logic [7:0] OFS_DAMP      = 8'h10;
   localparam logic [7:0] OFS_TARGET    = 8'h14;
   localparam logic [7:0] OFS_EXP_MIN   = 8'h18;
   localparam logic [7:0] OFS_EXP_MAX   = 8'h1C;
   localparam logic [7:0] OFS_GAIN_LIM  = 8'h20;
   localparam logic [7:0] OFS_EXP_OUT   = 8'h24;
   localparam logic [7:0] OFS_GAIN_OUT  = 8'h28;
   localparam logic [7:0] OFS_RATIO_OUT = 8'h2C;
   localparam logic [7:0] OFS_LEVELS    = 8'h30;
   // modes register field positions
   localparam int POS_PROFILE  = 0;
   localparam int POS_TGT_AUTO = 1;
   localparam int POS_LIGHT    = 2;
   localparam int POS_METER    = 4;
   localparam int POS_POLICY   = 8;
   // lighting compensation codes
   localparam logic [1:0] LIGHT_NORMAL = 2'h0;
   localparam logic [1:0] LIGHT_BACK   = 2'h1;
   localparam logic [1:0] LIGHT_FRONT  = 2'h2;
   localparam logic [1:0] LIGHT_AUTO   = 2'h3;
   // light measure codes; centre weighted and histogram fall back to average
   localparam logic [2:0] METER_AVG     = 3'h0;
   localparam logic [2:0] METER_SPOT    = 3'h1;
   localparam logic [2:0] METER_PARTIAL = 3'h2;
   localparam logic [2:0] METER_CENTRE  = 3'h3;
   localparam logic [2:0] METER_HIST    = 3'h4;
   localparam logic       PROFILE_INDOOR  = 1'b0;
   localparam logic       PROFILE_OUTDOOR = 1'b1;
   localparam logic       TGT_SEL_USER    = 1'b0;
   localparam logic       TGT_SEL_CONT    = 1'b1;
   localparam logic       POLICY_GAIN     = 1'b0;
   localparam logic       POLICY_EXPOSURE = 1'b1;
   // reset values; damping is a fraction of 256, ratios are q8.8, gain in 1/16 dB
   localparam logic [15:0] RST_ROI_H      = 16'h0100;
   localparam logic [15:0] RST_RATIO_MIN  = 16'h0040;
   localparam logic [15:0] RST_RATIO_MAX  = 16'h0400;
   localparam logic [15:0] RST_RATIO      = 16'h0100;
   localparam logic [7:0]  RST_COL_DAMP   = 8'h33;
   localparam logic [7:0]  RST_EXP_DAMP   = 8'h33;
   localparam logic [7:0]  RST_TGT_USER   = 8'h32;
   localparam logic [7:0]  RST_TGT_FLOOR  = 8'h05;
   localparam logic [7:0]  RST_TGT_CEIL   = 8'h5A;
   localparam logic [23:0] RST_EXP_MIN    = 24'h000064;
   localparam logic [23:0] RST_EXP_MAX    = 24'h007530;
   localparam logic [15:0] RST_GAIN_MIN   = 16'h0000;
   localparam logic [15:0] RST_GAIN_MAX   = 16'h0180;
   // exposure priority fixed time, in milliseconds and in microseconds
   localparam int          EXP_FIXED_MS   = 5;
   localparam logic [23:0] EXP_FIXED_US   = 24'(EXP_FIXED_MS * 1000);
   localparam logic [7:0]  TGT_AUTO_PCT   = 8'h32;
   localparam logic [7:0]  TGT_PER_THIRD  = 8'h03;
   localparam logic [7:0]  AUTO_LIGHT_THR = 8'h14;
   localparam int          EXP_STEP_SHIFT = 2;
   localparam int          GAIN_STEP_SHIFT = 8;
   localparam logic [8:0]  DAMP_ONE       = 9'h100;
   localparam logic [15:0] OUTDOOR_R_BIAS = 16'h0010;
   localparam logic [15:0] OUTDOOR_B_BIAS = 16'h0010;
endpackage

// ===== rtl/ae_awb_ctrl.sv
// exposure and colour balance control loops with an ahb-lite register slave
// assumes per-frame statistics on the same clock, linear (pre-gamma) means in percent
//
// How it works
// RQ1: one roi height per algorithm, accessed through the algorithm selector
// RQ2: colour balance profile is indoor or outdoor
// RQ3: red and blue ratios clamped between ratio minimum and maximum
// RQ4: larger colour damping gives smaller ratio steps
// RQ5: target level is automatic or the user value, by a select bit
// RQ6: user target is percent of mean, compared against linear pre-gamma means
// RQ7: lighting mode backlight, frontlight, normal or auto-detect; normal after reset
// RQ8: average metering uses the whole-area mean
// RQ9: spot metering uses only the small central mean
// RQ10: partial metering uses the larger central mean
// RQ11: metering choice applies only under normal lighting and is written only by a modes write that selects normal lighting
// RQ12: exposure kept within exposure limits in microseconds
// RQ13: gain kept within gain limits
// RQ14: target level confined between floor and ceiling percentages
// RQ15: brightness offset in thirds from -3 to +3, positive brightens
// RQ16: exposure damping 0 to 1, default 0.2, sets settling speed
// RQ17: gain priority keeps gain at 0 dB until exposure hits its maximum
// RQ18: exposure priority fixes 5 ms exposure until gain hits its maximum
// RQ19: priority policy has exactly two values
// RQ20: a floor above its ceiling clamps to the ceiling
`timescale 1ns/10ps
`default_nettype none
module ae_awb_ctrl (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        stat_valid,
   input  wire logic [7:0]  mean_full,
   input  wire logic [7:0]  mean_spot,
   input  wire logic [7:0]  mean_partial,
   input  wire logic        awb_valid,
   input  wire logic [15:0] red_ratio_want,
   input  wire logic [15:0] blue_ratio_want,
   output logic [23:0]      exposure_us,
   output logic [15:0]      gain_out,
   output logic [15:0]      red_ratio,
   output logic [15:0]      blue_ratio,
   output logic [15:0]      roi_height_ae,
   output logic [15:0]      roi_height_awb
);
   // saturating clamp; a floor above the ceiling yields the ceiling
   function automatic logic [23:0] clamp(input logic signed [25:0] v,
                                         input logic [23:0] lo,
                                         input logic [23:0] hi);
      logic [23:0] r;
      r = '0;
      if (lo > hi)
         r = hi; // RQ20
      else if (v < $signed({2'b00, lo}))
         r = lo;
      else if (v > $signed({2'b00, hi}))
         r = hi;
      else
         r = v[23:0];
      return r;
   endfunction

   // bus address phase capture
   logic        wr_pend_ff;
   logic [7:0]  addr_ff;
   // settings
   logic        algo_sel_ff;
   logic [15:0] roi_h_ff [2];
   logic        profile_ff;
   logic        tgt_auto_ff;
   logic [1:0]  light_ff;
   logic [2:0]  meter_ff;
   logic        policy_ff;
   logic [15:0] ratio_min_ff;
   logic [15:0] ratio_max_ff;
   logic [7:0]  col_damp_ff;
   logic [7:0]  exp_damp_ff;
   logic [7:0]  tgt_user_ff;
   logic [7:0]  tgt_floor_ff;
   logic [7:0]  tgt_ceil_ff;
   logic [7:0]  ev_ff;
   logic [23:0] exp_min_ff;
   logic [23:0] exp_max_ff;
   logic [15:0] gain_min_ff;
   logic [15:0] gain_max_ff;
   // loop state
   logic [23:0] exp_ff;
   logic [15:0] gain_ff;
   logic [15:0] red_ff;
   logic [15:0] blue_ff;
   logic [7:0]  meas_ff;

   wire addr_ok  = hsel & hready & htrans[1];
   wire wr_go    = wr_pend_ff;
   wire [7:0] ra = haddr[7:0];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         addr_ff    <= '0;
      end else if (hready) begin
         wr_pend_ff <= addr_ok & hwrite;
         addr_ff    <= haddr[7:0];
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // write decode
   wire we_sel   = wr_go && addr_ff == ae_awb_pkg::OFS_ALGO_SEL;
   wire we_roi   = wr_go && addr_ff == ae_awb_pkg::OFS_ROI_H;
   wire we_modes = wr_go && addr_ff == ae_awb_pkg::OFS_MODES;
   wire we_rlim  = wr_go && addr_ff == ae_awb_pkg::OFS_RATIO_LIM;
   wire we_damp  = wr_go && addr_ff == ae_awb_pkg::OFS_DAMP;
   wire we_tgt   = wr_go && addr_ff == ae_awb_pkg::OFS_TARGET;
   wire we_emin  = wr_go && addr_ff == ae_awb_pkg::OFS_EXP_MIN;
   wire we_emax  = wr_go && addr_ff == ae_awb_pkg::OFS_EXP_MAX;
   wire we_glim  = wr_go && addr_ff == ae_awb_pkg::OFS_GAIN_LIM;

   wire [1:0] wr_light = hwdata[ae_awb_pkg::POS_LIGHT +: 2];
   // metering only takes a modes write whose own lighting field selects normal lighting
   wire meter_wr = we_modes && wr_light == ae_awb_pkg::LIGHT_NORMAL; // RQ11

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         algo_sel_ff <= 1'b0;
         profile_ff  <= ae_awb_pkg::PROFILE_INDOOR;
         tgt_auto_ff <= ae_awb_pkg::TGT_SEL_CONT;
         light_ff    <= ae_awb_pkg::LIGHT_NORMAL; // RQ7
         meter_ff    <= ae_awb_pkg::METER_AVG;
         policy_ff   <= ae_awb_pkg::POLICY_GAIN;
      end else begin
         if (we_sel)
            algo_sel_ff <= hwdata[0];
         if (we_modes) begin
            profile_ff  <= hwdata[ae_awb_pkg::POS_PROFILE]; // RQ2
            tgt_auto_ff <= hwdata[ae_awb_pkg::POS_TGT_AUTO]; // RQ5
            light_ff    <= wr_light; // RQ7
            policy_ff   <= hwdata[ae_awb_pkg::POS_POLICY]; // RQ19
         end
         if (meter_wr)
            meter_ff <= hwdata[ae_awb_pkg::POS_METER +: 3]; // RQ11
      end
   end

   generate
      for (genvar i = 0; i < 2; i++) begin : g_roi
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn)
               roi_h_ff[i] <= ae_awb_pkg::RST_ROI_H;
            else if (we_roi && algo_sel_ff == 1'(i))
               roi_h_ff[i] <= hwdata[15:0]; // RQ1
         end
      end
   endgenerate

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ratio_min_ff <= ae_awb_pkg::RST_RATIO_MIN;
         ratio_max_ff <= ae_awb_pkg::RST_RATIO_MAX;
         col_damp_ff  <= ae_awb_pkg::RST_COL_DAMP;
         exp_damp_ff  <= ae_awb_pkg::RST_EXP_DAMP; // RQ16
         tgt_user_ff  <= ae_awb_pkg::RST_TGT_USER;
         tgt_floor_ff <= ae_awb_pkg::RST_TGT_FLOOR;
         tgt_ceil_ff  <= ae_awb_pkg::RST_TGT_CEIL;
         ev_ff        <= '0; // RQ15
         exp_min_ff   <= ae_awb_pkg::RST_EXP_MIN;
         exp_max_ff   <= ae_awb_pkg::RST_EXP_MAX;
         gain_min_ff  <= ae_awb_pkg::RST_GAIN_MIN;
         gain_max_ff  <= ae_awb_pkg::RST_GAIN_MAX;
      end else begin
         if (we_rlim) begin
            ratio_min_ff <= hwdata[15:0];
            ratio_max_ff <= hwdata[31:16];
         end
         if (we_damp) begin
            col_damp_ff <= hwdata[7:0];
            exp_damp_ff <= hwdata[15:8];
         end
         if (we_tgt) begin
            tgt_user_ff  <= hwdata[7:0];
            tgt_floor_ff <= hwdata[15:8];
            tgt_ceil_ff  <= hwdata[23:16];
            ev_ff        <= hwdata[31:24];
         end
         if (we_emin)
            exp_min_ff <= hwdata[23:0];
         if (we_emax)
            exp_max_ff <= hwdata[23:0];
         if (we_glim) begin
            gain_min_ff <= hwdata[15:0];
            gain_max_ff <= hwdata[31:16];
         end
      end
   end

   // brightness offset in thirds, held to -9..+9
   wire signed [7:0] ev_s   = ev_ff;
   wire signed [7:0] ev_lim = (ev_s > 8'sd9) ? 8'sd9 : (ev_s < -8'sd9) ? -8'sd9 : ev_s; // RQ15
   wire [7:0]  tgt_base = (tgt_auto_ff == ae_awb_pkg::TGT_SEL_CONT) ?
                          ae_awb_pkg::TGT_AUTO_PCT : tgt_user_ff; // RQ5
   wire signed [15:0] ev_adj = ev_lim * $signed({1'b0, ae_awb_pkg::TGT_PER_THIRD});
   wire signed [25:0] tgt_raw = $signed({18'd0, tgt_base}) + 26'(ev_adj); // RQ15
   wire [23:0] tgt_c = clamp(tgt_raw, {16'd0, tgt_floor_ff}, {16'd0, tgt_ceil_ff}); // RQ14
   wire [7:0]  tgt_eff = tgt_c[7:0];

   // measured level selection
   wire [7:0] d_spot = (mean_spot > mean_full) ? mean_spot - mean_full : 8'h00;
   wire [7:0] d_dark = (mean_full > mean_spot) ? mean_full - mean_spot : 8'h00;
   logic [7:0] meas_sel;
   always_comb begin
      meas_sel = mean_full; // RQ8
      unique case (light_ff)
         ae_awb_pkg::LIGHT_NORMAL: begin
            if (meter_ff == ae_awb_pkg::METER_SPOT)
               meas_sel = mean_spot; // RQ9
            else if (meter_ff == ae_awb_pkg::METER_PARTIAL)
               meas_sel = mean_partial; // RQ10
            else
               meas_sel = mean_full; // RQ8
         end
         ae_awb_pkg::LIGHT_BACK:  meas_sel = mean_partial; // RQ7
         ae_awb_pkg::LIGHT_FRONT: meas_sel = mean_spot; // RQ7
         ae_awb_pkg::LIGHT_AUTO: begin
            if (d_spot > ae_awb_pkg::AUTO_LIGHT_THR)
               meas_sel = mean_spot;
            else if (d_dark > ae_awb_pkg::AUTO_LIGHT_THR)
               meas_sel = mean_partial;
            else
               meas_sel = mean_full;
         end
      endcase
   end

   // error and damped step size
   wire signed [8:0] err = $signed({1'b0, tgt_eff}) - $signed({1'b0, meas_sel}); // RQ6
   wire [7:0]  err_mag  = err[8] ? 8'(-err) : err[7:0];
   wire [8:0]  exp_keep = ae_awb_pkg::DAMP_ONE - {1'b0, exp_damp_ff};
   wire [16:0] e_prod   = err_mag * exp_keep; // RQ16
   wire [23:0] exp_step = 24'(e_prod) << ae_awb_pkg::EXP_STEP_SHIFT;
   wire [15:0] g_raw    = 16'(e_prod >> ae_awb_pkg::GAIN_STEP_SHIFT);
   wire [15:0] gain_step = (g_raw == 16'h0 && e_prod != 17'h0) ? 16'h0001 : g_raw;
   wire brighter = ~err[8] & (err != 9'sd0);
   wire darker   = err[8];

   wire [23:0] gain_zero = clamp(26'sd0, {8'd0, gain_min_ff}, {8'd0, gain_max_ff});
   wire [23:0] exp_fixed = clamp($signed({2'b00, ae_awb_pkg::EXP_FIXED_US}), exp_min_ff, exp_max_ff);
   wire [23:0] exp_top   = exp_max_ff;
   wire [15:0] gain_top  = gain_max_ff;

   wire signed [25:0] exp_up  = $signed({2'b00, exp_ff}) + $signed({2'b00, exp_step});
   wire signed [25:0] exp_dn  = $signed({2'b00, exp_ff}) - $signed({2'b00, exp_step});
   wire signed [25:0] gain_up = $signed({10'd0, gain_ff}) + $signed({10'd0, gain_step});
   wire signed [25:0] gain_dn = $signed({10'd0, gain_ff}) - $signed({10'd0, gain_step});
   wire signed [25:0] exp_now  = $signed({2'b00, exp_ff});
   wire signed [25:0] gain_now = $signed({10'd0, gain_ff});

   logic signed [25:0] exp_cand;
   logic signed [25:0] gain_cand;
   always_comb begin
      exp_cand  = exp_now;
      gain_cand = gain_now;
      if (policy_ff == ae_awb_pkg::POLICY_GAIN) begin
         if (brighter) begin
            if (exp_ff >= exp_top)
               gain_cand = gain_up; // RQ17
            else
               exp_cand = exp_up; // RQ17
         end else if (darker) begin
            if (gain_ff > gain_zero[15:0])
               gain_cand = gain_dn; // RQ17
            else
               exp_cand = exp_dn; // RQ17
         end
      end else begin
         // exposure sits at the fixed short time unless gain has run out
         if (exp_ff < exp_fixed)
            exp_cand = $signed({2'b00, exp_fixed}); // RQ18
         if (brighter) begin
            if (gain_ff >= gain_top)
               exp_cand = exp_up; // RQ18
            else
               gain_cand = gain_up; // RQ18
         end else if (darker) begin
            if (exp_ff > exp_fixed)
               exp_cand = exp_dn; // RQ18
            else
               gain_cand = gain_dn; // RQ18
         end
      end
   end

   wire [23:0] nxt_exp  = clamp(exp_cand, exp_min_ff, exp_max_ff); // RQ12
   wire [23:0] nxt_gain = clamp(gain_cand, {8'd0, gain_min_ff}, {8'd0, gain_max_ff}); // RQ13

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         exp_ff  <= ae_awb_pkg::RST_EXP_MIN;
         gain_ff <= ae_awb_pkg::RST_GAIN_MIN;
         meas_ff <= '0;
      end else if (stat_valid) begin
         exp_ff  <= nxt_exp;
         gain_ff <= nxt_gain[15:0];
         meas_ff <= meas_sel;
      end
   end

   // colour balance: damped move toward wanted ratio, red plus and blue minus the profile bias
   wire outdoor = profile_ff == ae_awb_pkg::PROFILE_OUTDOOR;
   wire [15:0] r_bias = outdoor ? ae_awb_pkg::OUTDOOR_R_BIAS : 16'h0000; // RQ2
   wire [15:0] b_bias = outdoor ? ae_awb_pkg::OUTDOOR_B_BIAS : 16'h0000; // RQ2
   wire [8:0]  col_keep = ae_awb_pkg::DAMP_ONE - {1'b0, col_damp_ff};
   wire signed [17:0] r_diff = $signed({2'b00, red_ratio_want}) + $signed({2'b00, r_bias})
                               - $signed({2'b00, red_ff});
   wire signed [17:0] b_diff = $signed({2'b00, blue_ratio_want}) - $signed({2'b00, b_bias})
                               - $signed({2'b00, blue_ff});
   wire signed [27:0] r_prod = r_diff * $signed({1'b0, col_keep}); // RQ4
   wire signed [27:0] b_prod = b_diff * $signed({1'b0, col_keep}); // RQ4
   wire signed [25:0] r_cand = $signed({10'd0, red_ff}) + 26'(r_prod >>> 8);
   wire signed [25:0] b_cand = $signed({10'd0, blue_ff}) + 26'(b_prod >>> 8);
   wire [23:0] nxt_red  = clamp(r_cand, {8'd0, ratio_min_ff}, {8'd0, ratio_max_ff}); // RQ3
   wire [23:0] nxt_blue = clamp(b_cand, {8'd0, ratio_min_ff}, {8'd0, ratio_max_ff}); // RQ3

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         red_ff  <= ae_awb_pkg::RST_RATIO;
         blue_ff <= ae_awb_pkg::RST_RATIO;
      end else if (awb_valid) begin
         red_ff  <= nxt_red[15:0];
         blue_ff <= nxt_blue[15:0];
      end
   end

   // read mux, registered at the end of the address phase
   wire [31:0] modes_rd = {23'd0, policy_ff, 1'b0, meter_ff, light_ff, tgt_auto_ff, profile_ff};
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (ra)
         ae_awb_pkg::OFS_ALGO_SEL:  rd_mux = {31'd0, algo_sel_ff};
         ae_awb_pkg::OFS_ROI_H:     rd_mux = {16'd0, roi_h_ff[algo_sel_ff]}; // RQ1
         ae_awb_pkg::OFS_MODES:     rd_mux = modes_rd;
         ae_awb_pkg::OFS_RATIO_LIM: rd_mux = {ratio_max_ff, ratio_min_ff};
         ae_awb_pkg::OFS_DAMP:      rd_mux = {16'd0, exp_damp_ff, col_damp_ff};
         ae_awb_pkg::OFS_TARGET:    rd_mux = {ev_ff, tgt_ceil_ff, tgt_floor_ff, tgt_user_ff};
         ae_awb_pkg::OFS_EXP_MIN:   rd_mux = {8'd0, exp_min_ff};
         ae_awb_pkg::OFS_EXP_MAX:   rd_mux = {8'd0, exp_max_ff};
         ae_awb_pkg::OFS_GAIN_LIM:  rd_mux = {gain_max_ff, gain_min_ff};
         ae_awb_pkg::OFS_EXP_OUT:   rd_mux = {8'd0, exp_ff};
         ae_awb_pkg::OFS_GAIN_OUT:  rd_mux = {16'd0, gain_ff};
         ae_awb_pkg::OFS_RATIO_OUT: rd_mux = {blue_ff, red_ff};
         ae_awb_pkg::OFS_LEVELS:    rd_mux = {16'd0, meas_ff, tgt_eff};
         default:                   rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata <= '0;
      else if (addr_ok && !hwrite)
         hrdata <= rd_mux;
   end

   assign exposure_us    = exp_ff;
   assign gain_out       = gain_ff;
   assign red_ratio      = red_ff;
   assign blue_ratio     = blue_ff;
   assign roi_height_ae  = roi_h_ff[0];
   assign roi_height_awb = roi_h_ff[1];
endmodule
`default_nettype wire

// ===== verif/ae_awb_ctrl_asserts.sv
// concurrent checks on the exposure and colour balance controller ports
// assumes binding to ae_awb_ctrl, single clock hclk, async active-low hresetn
`timescale 1ns/10ps
`default_nettype none
module ae_awb_chk (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        stat_valid,
   input wire logic        awb_valid,
   input wire logic [23:0] exposure_us,
   input wire logic [15:0] gain_out,
   input wire logic [15:0] red_ratio,
   input wire logic [15:0] blue_ratio,
   input wire logic [15:0] roi_height_ae,
   input wire logic [15:0] roi_height_awb
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic roi_wr_ff;
   wire  take    = hsel & hready & htrans[1];
   wire  rd_req  = take & ~hwrite;
   wire  roi_req = take & hwrite & (haddr[7:0] == ae_awb_pkg::OFS_ROI_H);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) roi_wr_ff <= 1'b0;
      else roi_wr_ff <= roi_req;
   end
   a_zero_wait: assert property (take |-> hreadyout && !hresp ##1 hreadyout && !hresp) else $error("bus stall");
   a_rdata_hold: assert property ($changed(hrdata) |-> $past(rd_req)) else $error("read data moved unasked");
   a_exp_on_frame: assert property ($changed(exposure_us) |-> $past(stat_valid)) else $error("exposure moved");
   a_gain_on_frame: assert property ($changed(gain_out) |-> $past(stat_valid)) else $error("gain moved");
   a_red_on_stat: assert property ($changed(red_ratio) |-> $past(awb_valid)) else $error("red ratio moved");
   a_blue_on_stat: assert property ($changed(blue_ratio) |-> $past(awb_valid)) else $error("blue ratio moved");
   a_roi_ae_write: assert property ($changed(roi_height_ae) |-> $past(roi_wr_ff)) else $error("ae roi moved");
   a_roi_awb_write: assert property ($changed(roi_height_awb) |-> $past(roi_wr_ff)) else $error("awb roi moved");
   c_frame: cover property (stat_valid ##1 $changed(exposure_us));
   c_colour: cover property (awb_valid ##1 $changed(red_ratio));
   c_roi: cover property (roi_req);
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// self-checking bench for the exposure and colour balance controller
// assumes the controller is the only slave on a zero-wait ahb-lite bus
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic             hclk, hresetn, hsel, hwrite, stat_valid, awb_valid;
   logic [31:0]      haddr, hwdata, rv;
   logic [1:0]       htrans;
   logic [7:0]       m_full, m_spot, m_part;
   logic [15:0]      red_want, blue_want;
   wire logic        hreadyout, hresp;
   wire logic [31:0] hrdata;
   wire logic [23:0] exposure_us;
   wire logic [15:0] gain_out, red_ratio, blue_ratio, roi_ae, roi_awb;
   int               mismatches, n_tests, st, gs;
   ae_awb_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .stat_valid(stat_valid), .mean_full(m_full), .mean_spot(m_spot),
      .mean_partial(m_part), .awb_valid(awb_valid), .red_ratio_want(red_want),
      .blue_ratio_want(blue_want), .exposure_us(exposure_us), .gain_out(gain_out),
      .red_ratio(red_ratio), .blue_ratio(blue_ratio), .roi_height_ae(roi_ae), .roi_height_awb(roi_awb));
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // address phase held until hready, then data phase held until hready
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0);
      chk(rv, e);
   endtask
   task frame(input logic [7:0] f, s, p);
      @(posedge hclk);
      stat_valid <= 1'b1;
      m_full <= f;
      m_spot <= s;
      m_part <= p;
      @(posedge hclk);
      stat_valid <= 1'b0;
      @(posedge hclk);
   endtask
   task wb(input logic [15:0] r, b);
      @(posedge hclk);
      awb_valid <= 1'b1;
      red_want <= r;
      blue_want <= b;
      @(posedge hclk);
      awb_valid <= 1'b0;
      @(posedge hclk);
   endtask
   task rst;
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
   endtask
   task t_reset;
      chk({gain_out, exposure_us[15:0]}, 32'h00000064);
      rdc(8'h08, 32'h2);
      rdc(8'h0C, 32'h04000040);
      rdc(8'h10, 32'h3333);
      rdc(8'h14, 32'h005A0532);
      rdc(8'h1C, 32'h7530);
      rdc(8'h20, 32'h01800000);
      rdc(8'h3C, 32'h0);
   endtask
   task t_roi;
      ahb(1'b1, 8'h00, 32'h0);
      ahb(1'b1, 8'h04, 32'h0123);
      ahb(1'b1, 8'h00, 32'h1);
      ahb(1'b1, 8'h04, 32'h0456);
      rdc(8'h04, 32'h0456);
      chk({roi_awb, roi_ae}, 32'h04560123);
      ahb(1'b1, 8'h00, 32'h0);
      rdc(8'h04, 32'h0123);
   endtask
   task t_modes;
      ahb(1'b1, 8'h08, 32'h125);
      rdc(8'h08, 32'h105);
      for (int m = 0; m < 5; m++) begin
         ahb(1'b1, 8'h08, 32'(m * 16) | 32'h101);
         rdc(8'h08, 32'(m * 16) | 32'h101);
      end
   endtask
   task t_target;
      logic [31:0] tv [6];
      logic [7:0]  te [6];
      tv = '{32'h095A0532, 32'hF75A0532, 32'h09460532, 32'h003C4632, 32'h005A0514, 32'h005A0514};
      te = '{8'h4D, 8'h17, 8'h46, 8'h3C, 8'h14, 8'h32};
      for (int i = 0; i < 6; i++) begin
         ahb(1'b1, 8'h08, i == 5 ? 32'h2 : 32'h0);
         ahb(1'b1, 8'h14, tv[i]);
         frame(8'h32, 8'h32, 8'h32);
         rdc(8'h30, {16'h0, 8'h32, te[i]});
      end
   endtask
   task t_gain_pol;
      ahb(1'b1, 8'h08, 32'h10);
      frame(8'h32, 8'h28, 8'h32);
      chk({gain_out, exposure_us[15:0]}, 32'(100 + st));
      ahb(1'b1, 8'h08, 32'h20);
      frame(8'h32, 8'h32, 8'h28);
      chk(32'(exposure_us), 32'(100 + 2 * st));
      ahb(1'b1, 8'h08, 32'h0);
      frame(8'h28, 8'h32, 8'h32);
      chk(32'(exposure_us), 32'(100 + 3 * st));
      frame(8'h28, 8'h32, 8'h32);
      chk({gain_out, exposure_us[15:0]}, 32'h00007530);
      frame(8'h28, 8'h32, 8'h32);
      chk(32'(gain_out), 32'(gs));
      ahb(1'b1, 8'h08, 32'h4);
      frame(8'h32, 8'h32, 8'h28);
      chk(32'(gain_out), 32'(2 * gs));
      ahb(1'b1, 8'h08, 32'h8);
      frame(8'h32, 8'h28, 8'h32);
      chk(32'(gain_out), 32'(3 * gs));
      ahb(1'b1, 8'h08, 32'hC);
      frame(8'h14, 8'h3C, 8'h32);
      chk(32'(gain_out), 32'(2 * gs));
      frame(8'h3C, 8'h14, 8'h32);
      chk(32'(gain_out), 32'(2 * gs));
      ahb(1'b1, 8'h24, 32'h0);
      rdc(8'h24, 32'h7530);
   endtask
   task t_exp_pol;
      ahb(1'b1, 8'h08, 32'h100);
      frame(8'h28, 8'h28, 8'h28);
      chk({gain_out, exposure_us[15:0]}, {16'(gs), 16'(ae_awb_pkg::EXP_FIXED_US)});
      ahb(1'b1, 8'h20, {16'(gs), 16'h0});
      frame(8'h28, 8'h28, 8'h28);
      chk({gain_out, exposure_us[15:0]}, {16'(gs), 16'(ae_awb_pkg::EXP_FIXED_US + st)});
      ahb(1'b1, 8'h20, 32'h00040010);
      frame(8'h28, 8'h28, 8'h28);
      chk(32'(gain_out), 32'h4);
   endtask
   task t_awb;
      wb(16'h0200, 16'h0080);
      chk({blue_ratio, red_ratio}, 32'h009901CD);
      ahb(1'b1, 8'h10, 32'h33F0);
      wb(16'h0200, 16'h0080);
      chk(32'(red_ratio), 32'h01D0);
      ahb(1'b1, 8'h0C, 32'h01800080);
      ahb(1'b1, 8'h10, 32'h3300);
      wb(16'h0400, 16'h0000);
      chk({blue_ratio, red_ratio}, 32'h00800180);
      ahb(1'b1, 8'h0C, 32'h04000040);
      ahb(1'b1, 8'h08, 32'h3);
      wb(16'h0100, 16'h0100);
      rdc(8'h2C, 32'h00F00110);
   endtask
   initial begin
      hsel = 1'b1;
      htrans = 2'h0;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      {stat_valid, awb_valid, m_full, m_spot, m_part, red_want, blue_want} = '0;
      st = 10 * (ae_awb_pkg::DAMP_ONE - ae_awb_pkg::RST_EXP_DAMP);
      gs = st >> ae_awb_pkg::GAIN_STEP_SHIFT;
      st = st << ae_awb_pkg::EXP_STEP_SHIFT;
      rst;
      t_reset;
      t_roi;
      t_modes;
      t_target;
      rst;
      t_gain_pol;
      rst;
      t_exp_pol;
      rst;
      t_awb;
      test_done;
   end
   initial begin
      #20000;
      mismatches++;
      test_done;
   end
endmodule
bind ae_awb_ctrl ae_awb_chk chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout,
   .hresp, .hrdata, .stat_valid, .awb_valid, .exposure_us, .gain_out, .red_ratio, .blue_ratio,
   .roi_height_ae, .roi_height_awb);
`default_nettype wire
